// ==== shared/fob_pkg.sv ====
// ---------------------------------------------------------------------------
// Shared constants and types for the oversampling block buffer.
// ---------------------------------------------------------------------------
package fob_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register word addresses.
  localparam logic [7:0] REG_MAP_DIST1  = 8'h00;
  localparam logic [7:0] REG_MAP_DIST2  = 8'h01;
  localparam logic [7:0] REG_MAP_CALC   = 8'h02;
  localparam logic [7:0] REG_PEAK_COUNT = 8'h03;
  localparam logic [7:0] REG_CALC_TYPE  = 8'h04;
  localparam logic [7:0] REG_COEF_ONE   = 8'h05;
  localparam logic [7:0] REG_COEF_TWO   = 8'h06;
  localparam logic [7:0] REG_COEF_OFS   = 8'h07;
  localparam logic [7:0] REG_PRESET     = 8'h08;
  localparam logic [7:0] REG_STATUS     = 8'h09;
  localparam logic [7:0] REG_NAME_BASE  = 8'h10;

  // Status field positions.
  localparam int unsigned ST_CODE_LSB  = 0;
  localparam int unsigned ST_AVAIL_BIT = 2;
  localparam int unsigned ST_ERR_BIT   = 3;
  localparam int unsigned ST_NAME_LSB  = 4;
  localparam int unsigned ST_BANK_BIT  = 7;
  localparam int unsigned ST_SEQ_LSB   = 16;

  // Mapping base indices; base plus k selects factor two to the k.
  localparam logic [15:0] MAP_BASE_DIST1 = 16'h1A00;
  localparam logic [15:0] MAP_BASE_DIST2 = 16'h1A10;
  localparam logic [15:0] MAP_BASE_CALC  = 16'h1B00;
  localparam logic [15:0] MAP_CODE_LIMIT = 16'h0004;

  // Values after reset.
  localparam logic [15:0] MAP_DIST1_RST = 16'h1A00;
  localparam logic [7:0]  PEAK_RST      = 8'h01;

  // Calculation and preset encodings.
  localparam logic [7:0]  CALC_NONE   = 8'h00;
  localparam logic [7:0]  CALC_THICK  = 8'h04;
  localparam logic [7:0]  PEAK_TWO    = 8'h02;
  localparam logic [31:0] PRESET_SST  = 32'h00000001;
  localparam logic [31:0] COEF_PLUS1  = 32'h00010000;
  localparam logic [31:0] COEF_MINUS1 = 32'hFFFF0000;
  localparam int unsigned Q_SHIFT     = 16;

  // Link state codes as driven by the fieldbus state machine.
  localparam logic [1:0] LS_INIT   = 2'h0;
  localparam logic [1:0] LS_PREOP  = 2'h1;
  localparam logic [1:0] LS_SAFEOP = 2'h2;
  localparam logic [1:0] LS_OP     = 2'h3;

  // Buffer geometry.
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned MAX_BLOCK  = 8;
  localparam int unsigned NAME_SLOTS = 4;

  // One measured-value record as it travels through the buffer.
  typedef struct packed {
    logic signed [31:0] dist1;
    logic signed [31:0] dist2;
    logic signed [31:0] calc;
  } fob_rec_s;

  localparam int unsigned REC_W = $bits(fob_rec_s);

endpackage

// ==== rtl/fob_block_buffer.sv ====
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------------
// Sample FIFO between acquisition and block builder.
// ---------------------------------------------------------------------------
module fob_fifo #(
  parameter int unsigned W     = 96,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  // Filling side.
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // Draining side.
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  // Whole FIFO state, storage included.
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;   // Storage words.
    logic [AW-1:0]           wr;    // Write pointer.
    logic [AW-1:0]           rd;    // Read pointer.
    logic [AW:0]             cnt;   // Words held.
    logic                    rdy;   // Room for one more word.
  } fob_fifo_st_s;

  localparam fob_fifo_st_s ST_RST = '{mem: '0, wr: '0, rd: '0, cnt: '0,
                                      rdy: 1'b1};

  fob_fifo_st_s st_q;     // Registered state.
  fob_fifo_st_s st_d;     // Next state.
  logic         push;     // Word accepted this cycle.
  logic         pop;      // Word removed this cycle.

  // Pointer and count update; ready is registered so that it is honest.
  always_comb
  begin
    st_d = st_q;
    push = in_valid_in && st_q.rdy;
    pop  = (st_q.cnt != '0) && out_ready_in;
    if (push)
    begin
      st_d.mem[st_q.wr] = in_data_in;
      st_d.wr           = st_q.wr + 1'b1;
    end
    if (pop)
    begin
      st_d.rd = st_q.rd + 1'b1;
    end
    if (push && !pop)
    begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
    st_d.rdy = (st_d.cnt != (AW+1)'(DEPTH));
  end

  // State register.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= ST_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign in_ready_out  = st_q.rdy;
  assign out_valid_out = (st_q.cnt != '0);
  assign out_data_out  = st_q.mem[st_q.rd];

endmodule

// ---------------------------------------------------------------------------
// Oversampling block buffer top.
// ---------------------------------------------------------------------------
module fob_block_buffer
  import fob_pkg::*;
(
  // Clock and reset.
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_in,
  // Register port.
  input  wire logic [fob_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [fob_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic      [fob_pkg::DATA_W-1:0] reg_rdata_out,
  // Measured-value samples.
  input  wire logic                       smp_valid_in,
  input  wire logic signed [31:0]         smp_dist1_in,
  input  wire logic signed [31:0]         smp_dist2_in,
  output logic                            smp_ready_out,
  // Fieldbus state and process-data pickup.
  input  wire logic [1:0]                 link_state_in,
  input  wire logic                       pd_busy_in,
  input  wire logic                       pd_rd_in,
  input  wire logic [2:0]                 pd_idx_in,
  output fob_pkg::fob_rec_s               pd_data_out,
  output logic                            pd_avail_out,
  output logic [1:0]                      pd_code_out,
  output logic [15:0]                     pd_seq_out
);
  import fob_pkg::*;

  // Whole state of the block.
  typedef struct packed {
    logic [15:0]                    map1;      // Distance one mapping.
    logic [15:0]                    map2;      // Distance two mapping.
    logic [15:0]                    map3;      // Calc slot mapping.
    logic [7:0]                     peak;      // Expected peak count.
    logic [7:0]                     ctype;     // Calculation type.
    logic [31:0]                    coef1;     // First coefficient, Q16.16.
    logic [31:0]                    coef2;     // Second coefficient, Q16.16.
    logic [31:0]                    ofs;       // Offset.
    logic [NAME_SLOTS-1:0][7:0]     names;     // Calculated signal list.
    logic [2:0]                     name_cnt;  // Entries in the list.
    logic                           err;       // Sticky rejected write.
    logic                           avail;     // Process data live.
    logic [1:0]                     act_code;  // Committed factor code.
    logic [2:0]                     act_en;    // Committed slot enables.
    logic [1:0]                     prev_ls;   // Previous link state.
    logic [2:0]                     fill_idx;  // Next slot in fill bank.
    logic                           fill_bank; // Bank being filled.
    logic [15:0]                    seq;       // Completed block count.
    logic [1:0][MAX_BLOCK-1:0][REC_W-1:0] bank; // Two record banks.
    logic [31:0]                    rdata;     // Register read data.
    fob_rec_s                       pd_data;   // Process-data read data.
  } fob_st_s;

  fob_st_s            st_q;        // Registered state.
  fob_st_s            st_d;        // Next state.
  fob_rec_s           smp_rec;     // Incoming record with calc result.
  logic signed [63:0] prod1;       // First coefficient product.
  logic signed [63:0] prod2;       // Second coefficient product.
  logic signed [63:0] prod_sum;    // Sum of products.
  logic               fifo_valid;  // Record waiting for the builder.
  logic               fifo_ready;  // Builder takes a record.
  logic [REC_W-1:0]   fifo_data;   // Record at the FIFO head.
  fob_rec_s           head_rec;    // Head as a record.
  fob_rec_s           rd_rec;      // Selected completed record.
  logic [2:0]         last_idx;    // Index of the final slot of a block.
  logic               last_slot;   // Next write completes the block.
  logic [2:0]         cfg_code;    // Ok flag and code of the selection.

  // Returns {ok, code} for a mapping index against its base.
  function automatic logic [2:0] map_code(input logic [15:0] idx,
                                          input logic [15:0] base);
    logic [15:0] diff;
    diff = idx - base;
    map_code = {(idx >= base) && (diff < MAP_CODE_LIMIT), diff[1:0]};
  endfunction

  // A new mapping is accepted when valid and matching the other entries.
  function automatic logic map_ok(input logic [15:0] idx,
                                  input logic [15:0] base,
                                  input logic [15:0] oa,
                                  input logic [15:0] ba,
                                  input logic [15:0] ob,
                                  input logic [15:0] bb);
    logic [2:0] cn;
    logic [2:0] ca;
    logic [2:0] cb;
    cn = map_code(idx, base);
    ca = map_code(oa, ba);
    cb = map_code(ob, bb);
    map_ok = (idx == '0) ||
             (cn[2] && ((oa == '0) || (ca[1:0] == cn[1:0])) &&
                       ((ob == '0) || (cb[1:0] == cn[1:0])));
  endfunction

  // -------------------------------------------------------------------------
  // Sample preparation and calculation.
  // -------------------------------------------------------------------------

  // The thickness formula is evaluated once per sample on its way in.
  always_comb
  begin
    prod1        = $signed(st_q.coef1) * smp_dist1_in;
    prod2        = $signed(st_q.coef2) * smp_dist2_in;
    prod_sum     = prod1 + prod2;
    smp_rec      = '0;
    smp_rec.dist1 = smp_dist1_in;
    // The second peak only exists when two peaks are expected.
    if (st_q.peak >= PEAK_TWO)
    begin
      smp_rec.dist2 = smp_dist2_in;
    end
    if (st_q.ctype == CALC_THICK)
    begin
      smp_rec.calc = 32'(prod_sum >>> Q_SHIFT) + $signed(st_q.ofs);
    end
  end

  // Samples queue here so that register traffic and swaps never drop one.
  fob_fifo #(
    .W     (REC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (smp_valid_in),
    .in_ready_out  (smp_ready_out),
    .in_data_in    (smp_rec),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_ready),
    .out_data_out  (fifo_data)
  );

  // -------------------------------------------------------------------------
  // Block building, registers and pickup.
  // -------------------------------------------------------------------------

  // A block may not complete while the master is reading, so the final
  // write stalls the FIFO instead; a long frame fills the FIFO up.
  always_comb
  begin
    head_rec  = fob_rec_s'(fifo_data);
    last_idx  = 3'((4'h1 << st_q.act_code) - 4'h1);
    last_slot = (st_q.fill_idx == last_idx);
    fifo_ready = !st_q.avail || !(last_slot && pd_busy_in);
    cfg_code  = (st_q.map1 != '0) ? map_code(st_q.map1, MAP_BASE_DIST1) :
                (st_q.map2 != '0) ? map_code(st_q.map2, MAP_BASE_DIST2) :
                map_code(st_q.map3, MAP_BASE_CALC);
    rd_rec    = fob_rec_s'(st_q.bank[!st_q.fill_bank][pd_idx_in]);
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    st_d         = st_q;
    st_d.prev_ls = link_state_in;

    // Link state: commit the selection on the preop to safeop step.
    if ((st_q.prev_ls == LS_PREOP) && (link_state_in == LS_SAFEOP))
    begin
      st_d.avail    = 1'b1;
      st_d.act_code = cfg_code[1:0];
      st_d.act_en   = {st_q.map3 != '0, st_q.map2 != '0,
                       st_q.map1 != '0};
      st_d.fill_idx = '0;
    end
    else if ((link_state_in == LS_INIT) || (link_state_in == LS_PREOP))
    begin
      st_d.avail = 1'b0;
    end

    // Builder: write the head into the fill bank, swap when full.
    if (fifo_valid && fifo_ready && st_q.avail)
    begin
      st_d.bank[st_q.fill_bank][st_q.fill_idx] = head_rec;
      if (last_slot)
      begin
        // Factor one swaps on every sample, so the newest one wins.
        st_d.fill_bank = !st_q.fill_bank;
        st_d.fill_idx  = '0;
        st_d.seq       = st_q.seq + 1'b1;
      end
      else
      begin
        st_d.fill_idx = st_q.fill_idx + 1'b1;
      end
    end

    // Pickup: the completed bank stays until the next swap.
    if (pd_rd_in)
    begin
      st_d.pd_data = '0;
      if (st_q.avail && ({1'b0, pd_idx_in} <= {1'b0, last_idx}))
      begin
        if (st_q.act_en[0])
        begin
          st_d.pd_data.dist1 = rd_rec.dist1;
        end
        if (st_q.act_en[1])
        begin
          st_d.pd_data.dist2 = rd_rec.dist2;
        end
        if (st_q.act_en[2])
        begin
          st_d.pd_data.calc = rd_rec.calc;
        end
      end
    end

    // Register writes.
    if (reg_wr_in)
    begin
      if ((reg_addr_in == REG_MAP_DIST1) || (reg_addr_in == REG_MAP_DIST2) ||
          (reg_addr_in == REG_MAP_CALC))
      begin
        // The selection is frozen after the preop to safeop step, until the link is back in init or preop.
        if (st_q.avail)
        begin
          st_d.err = 1'b1;
        end
        else if ((reg_addr_in == REG_MAP_DIST1) &&
                 map_ok(reg_wdata_in[15:0], MAP_BASE_DIST1,
                        st_q.map2, MAP_BASE_DIST2, st_q.map3, MAP_BASE_CALC))
        begin
          st_d.map1 = reg_wdata_in[15:0];
        end
        else if ((reg_addr_in == REG_MAP_DIST2) &&
                 map_ok(reg_wdata_in[15:0], MAP_BASE_DIST2,
                        st_q.map1, MAP_BASE_DIST1, st_q.map3, MAP_BASE_CALC))
        begin
          st_d.map2 = reg_wdata_in[15:0];
        end
        else if ((reg_addr_in == REG_MAP_CALC) &&
                 map_ok(reg_wdata_in[15:0], MAP_BASE_CALC,
                        st_q.map1, MAP_BASE_DIST1, st_q.map2, MAP_BASE_DIST2))
        begin
          st_d.map3 = reg_wdata_in[15:0];
        end
        else
        begin
          st_d.err = 1'b1;
        end
      end
      else if (reg_addr_in == REG_PEAK_COUNT)
      begin
        st_d.peak = reg_wdata_in[7:0];
      end
      else if (reg_addr_in == REG_CALC_TYPE)
      begin
        st_d.ctype = reg_wdata_in[7:0];
        // A newly defined signal takes the next free list entry.
        if ((reg_wdata_in[7:0] != CALC_NONE) &&
            (st_q.name_cnt < 3'(NAME_SLOTS)))
        begin
          st_d.names[st_q.name_cnt[1:0]] = reg_wdata_in[7:0];
          st_d.name_cnt = st_q.name_cnt + 1'b1;
        end
      end
      else if (reg_addr_in == REG_COEF_ONE)
      begin
        st_d.coef1 = reg_wdata_in;
      end
      else if (reg_addr_in == REG_COEF_TWO)
      begin
        st_d.coef2 = reg_wdata_in;
      end
      else if (reg_addr_in == REG_COEF_OFS)
      begin
        st_d.ofs = reg_wdata_in;
      end
      else if (reg_addr_in == REG_PRESET)
      begin
        // The preset also rewrites the coefficients, overwriting user ones.
        if (reg_wdata_in == PRESET_SST)
        begin
          st_d.peak  = PEAK_TWO;
          st_d.ctype = CALC_THICK;
          st_d.coef1 = COEF_MINUS1;
          st_d.coef2 = COEF_PLUS1;
          st_d.ofs   = '0;
          if (st_q.name_cnt < 3'(NAME_SLOTS))
          begin
            st_d.names[st_q.name_cnt[1:0]] = CALC_THICK;
            st_d.name_cnt = st_q.name_cnt + 1'b1;
          end
        end
      end
      else if (reg_addr_in == REG_STATUS)
      begin
        // Clearing the error flag; no mapping write, so no rejection, can share this cycle.
        st_d.err = 1'b0;
      end
    end
    // Register reads, answered one cycle later.
    if (reg_rd_in)
    begin
      st_d.rdata = '0;
      if (reg_addr_in == REG_MAP_DIST1)
      begin
        st_d.rdata = {16'h0000, st_q.map1};
      end
      else if (reg_addr_in == REG_MAP_DIST2)
      begin
        st_d.rdata = {16'h0000, st_q.map2};
      end
      else if (reg_addr_in == REG_MAP_CALC)
      begin
        st_d.rdata = {16'h0000, st_q.map3};
      end
      else if (reg_addr_in == REG_PEAK_COUNT)
      begin
        st_d.rdata = {24'h000000, st_q.peak};
      end
      else if (reg_addr_in == REG_CALC_TYPE)
      begin
        st_d.rdata = {24'h000000, st_q.ctype};
      end
      else if (reg_addr_in == REG_COEF_ONE)
      begin
        st_d.rdata = st_q.coef1;
      end
      else if (reg_addr_in == REG_COEF_TWO)
      begin
        st_d.rdata = st_q.coef2;
      end
      else if (reg_addr_in == REG_COEF_OFS)
      begin
        st_d.rdata = st_q.ofs;
      end
      else if (reg_addr_in == REG_STATUS)
      begin
        st_d.rdata[ST_CODE_LSB +: 2] = st_q.act_code;
        st_d.rdata[ST_AVAIL_BIT]     = st_q.avail;
        st_d.rdata[ST_ERR_BIT]       = st_q.err;
        st_d.rdata[ST_NAME_LSB +: 3] = st_q.name_cnt;
        st_d.rdata[ST_BANK_BIT]      = st_q.fill_bank;
        st_d.rdata[ST_SEQ_LSB +: 16] = st_q.seq;
      end
      else if ((reg_addr_in >= REG_NAME_BASE) &&
               (reg_addr_in < REG_NAME_BASE + 8'(NAME_SLOTS)))
      begin
        st_d.rdata = {24'h000000, st_q.names[reg_addr_in[1:0]]};
      end
    end
  end

  // State register; factory mapping selects distance one at factor one.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q      <= '0;
      st_q.map1 <= MAP_DIST1_RST;
      st_q.peak <= PEAK_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register.
  assign reg_rdata_out = st_q.rdata;
  assign pd_data_out   = st_q.pd_data;
  assign pd_avail_out  = st_q.avail;
  assign pd_code_out   = st_q.act_code;
  assign pd_seq_out    = st_q.seq;

endmodule

`default_nettype wire

// ==== dv/fob_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Cyclic master: one frame per request, one slot read inside it.
module fob_master_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire logic       slow_in,
  input  wire logic [2:0] idx_in,
  output logic            pd_busy_out,
  output logic            pd_rd_out,
  output logic [2:0]      pd_idx_out,
  output logic            done_out
);
  logic [3:0] cnt_q; // Cycles left in the frame.
  // A slow frame keeps busy up longer, holding off block swaps.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q       <= 4'h0;
      pd_busy_out <= 1'b0;
      pd_rd_out   <= 1'b0;
      pd_idx_out  <= 3'h0;
      done_out    <= 1'b0;
    end
    else
    begin
      pd_rd_out <= 1'b0;
      done_out  <= 1'b0;
      if (req_in && cnt_q == 4'h0)
      begin
        pd_busy_out <= 1'b1;
        pd_idx_out  <= idx_in;
        cnt_q       <= slow_in ? 4'h8 : 4'h2;
      end
      else if (cnt_q == 4'h2)
      begin
        pd_rd_out <= 1'b1;
        cnt_q     <= 4'h1;
      end
      else if (cnt_q == 4'h1)
      begin
        // Released index is scrambled so it is never reused by luck.
        pd_busy_out <= 1'b0;
        pd_idx_out  <= ~pd_idx_out;
        done_out    <= 1'b1;
        cnt_q       <= 4'h0;
      end
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== dv/fob_block_buffer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the block buffer.
module fob_block_buffer_checker
  import fob_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              rst_in,
  input wire logic              pd_busy_in,
  input wire logic              pd_rd_in,
  input wire logic [2:0]        pd_idx_in,
  input wire logic [1:0]        link_state_in,
  input wire fob_pkg::fob_rec_s pd_data_out,
  input wire logic              pd_avail_out,
  input wire logic [1:0]        pd_code_out,
  input wire logic [15:0]       pd_seq_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  gate_closed_a: assert property (
    link_state_in < LS_SAFEOP |=> !pd_avail_out)
    else $error("data live outside safeop");
  gate_opens_a: assert property (
    $rose(pd_avail_out) |-> $past(link_state_in) == LS_SAFEOP &&
    $past(link_state_in, 2) == LS_PREOP)
    else $error("data live without preop to safeop");
  swap_idle_a: assert property (
    $changed(pd_seq_out) |-> !$past(pd_busy_in) && $past(pd_avail_out))
    else $error("block swapped during a frame");
  seq_step_a: assert property (
    $changed(pd_seq_out) |-> pd_seq_out == $past(pd_seq_out) + 16'h0001)
    else $error("block count did not step by one");
  idle_zero_a: assert property (
    pd_rd_in && !pd_avail_out |=> pd_data_out == '0)
    else $error("data read while not live");
  slot_range_a: assert property (
    pd_rd_in && pd_avail_out && {1'b0, pd_idx_in} >= (4'h1 << pd_code_out)
    |=> pd_data_out == '0)
    else $error("slot beyond block size not zero");
  data_hold_a: assert property (
    !pd_rd_in |=> $stable(pd_data_out))
    else $error("pickup data moved without a read");
  code_hold_a: assert property (
    pd_avail_out && $past(pd_avail_out) |-> $stable(pd_code_out))
    else $error("factor changed while live");
  cover property ($rose(pd_avail_out));
  cover property ($changed(pd_seq_out));
  cover property (pd_rd_in && pd_avail_out);
endmodule
bind fob_block_buffer fob_block_buffer_checker fob_block_buffer_checker_i (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .pd_busy_in(pd_busy_in),
  .pd_rd_in(pd_rd_in), .pd_idx_in(pd_idx_in),
  .link_state_in(link_state_in), .pd_data_out(pd_data_out),
  .pd_avail_out(pd_avail_out), .pd_code_out(pd_code_out),
  .pd_seq_out(pd_seq_out));
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fob_pkg::*;
  logic               clk_sys_in, rst_in, wr, rd, sv, rdy, m_req, m_slow;
  logic               busy, prd, done, avail;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata, v;
  logic signed [31:0] d1, d2;
  logic signed [31:0] e1 [8];
  logic signed [31:0] e2 [8];
  logic [1:0]         link, code;
  logic [2:0]         m_idx, idx;
  logic [15:0]        seq, s0;
  fob_rec_s           pd, r;
  int                 failures, n_tests, cyc;
  fob_block_buffer fob_block_buffer_i (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .smp_valid_in(sv), .smp_dist1_in(d1), .smp_dist2_in(d2),
    .smp_ready_out(rdy), .link_state_in(link), .pd_busy_in(busy),
    .pd_rd_in(prd), .pd_idx_in(idx), .pd_data_out(pd),
    .pd_avail_out(avail), .pd_code_out(code), .pd_seq_out(seq));
  fob_master_model fob_master_model_i (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .req_in(m_req), .slow_in(m_slow), .idx_in(m_idx),
    .pd_busy_out(busy), .pd_rd_out(prd), .pd_idx_out(idx),
    .done_out(done));
  function automatic logic [31:0] thick(input logic [31:0] a, b);
    return b - a; // Coefficients -1.0 and +1.0, offset 0.
  endfunction
  task automatic chk(input string n, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Register strobes are one cycle; an idle edge separates them.
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(posedge clk_sys_in);
    d = rdata;
  endtask
  // Clearing the other maps first keeps every step consistent.
  task automatic cfg(input logic [15:0] m1, m2, mc);
    wreg(REG_MAP_DIST2, 32'h0);
    wreg(REG_MAP_CALC, 32'h0);
    wreg(REG_MAP_DIST1, {16'h0, m1});
    wreg(REG_MAP_DIST2, {16'h0, m2});
    wreg(REG_MAP_CALC, {16'h0, mc});
  endtask
  task automatic feed(input int n);
    logic [31:0] a;
    for (int i = 0; i < n; i++)
    begin
      a = $urandom;
      e1[i] = a;
      e2[i] = $urandom;
      sv <= 1'b1;
      d1 <= a;
      d2 <= e2[i];
      @(posedge clk_sys_in);
      while (rdy !== 1'b1) @(posedge clk_sys_in);
    end
    sv <= 1'b0;
    d1 <= ~d1;
  endtask
  task automatic wseq(input logic [15:0] t);
    for (int k = 0; k < 200 && seq !== t; k++) @(posedge clk_sys_in);
    chk("seq", seq, t);
  endtask
  task automatic pick(input logic [2:0] i, input logic s);
    m_idx <= i;
    m_slow <= s;
    m_req <= 1'b1;
    @(posedge clk_sys_in);
    m_req <= 1'b0;
    for (int k = 0; k < 20 && done !== 1'b1; k++) @(posedge clk_sys_in);
    r = pd;
  endtask
  task automatic blk(input int n, off);
    for (int i = 0; i < n; i++)
    begin
      pick(i[2:0], i[0]);
      chk("dist1", r.dist1, e1[i + off]);
      chk("dist2", r.dist2, e2[i + off]);
      chk("calc", r.calc, thick(e1[i + off], e2[i + off]));
    end
  endtask
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_of_test();
    end
  end
  initial
  begin
    {rst_in, wr, rd, sv, m_req, m_slow} = 6'h20;
    {addr, wdata, d1, d2, m_idx, link} = '0;
    void'($urandom(32'h337677A7));
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rreg(REG_MAP_DIST1, v);
    chk("map1", v, 32'h00001A00);
    rreg(8'h20, v);
    chk("unmapped", v, 32'h0);
    wreg(REG_PRESET, PRESET_SST);
    rreg(REG_PEAK_COUNT, v);
    chk("peak", v, 32'h2);
    rreg(REG_COEF_ONE, v);
    chk("coef1", v, COEF_MINUS1);
    rreg(REG_NAME_BASE, v);
    chk("name", v, 32'h4);
    link <= LS_PREOP;
    cfg(16'h1A02, 16'h1A12, 16'h1B02);
    wreg(REG_MAP_DIST2, 32'h00001A11);
    rreg(REG_MAP_DIST2, v);
    chk("map2", v, 32'h00001A12);
    rreg(REG_STATUS, v);
    chk("err", v & 32'h8, 32'h8);
    wreg(REG_STATUS, 32'h0);
    link <= LS_SAFEOP;
    repeat (3) @(posedge clk_sys_in);
    rreg(REG_STATUS, v);
    chk("status", v & 32'h7F, 32'h16);
    s0 = seq;
    feed(4);
    wseq(s0 + 16'h1);
    blk(4, 0);
    pick(3'h4, 1'b0);
    chk("beyond", r.dist1, 32'h0);
    feed(8);
    wseq(s0 + 16'h3);
    blk(4, 4);
    blk(1, 4);
    chk("repeat", seq, s0 + 16'h3);
    link <= LS_PREOP;
    @(posedge clk_sys_in);
    cfg(16'h1A00, 16'h1A10, 16'h1B00);
    link <= LS_SAFEOP;
    repeat (3) @(posedge clk_sys_in);
    s0 = seq;
    feed(3);
    wseq(s0 + 16'h3);
    blk(1, 2);
    link <= LS_OP;
    rreg(REG_STATUS, v);
    chk("live", v & 32'h4, 32'h4);
    end_of_test();
  end
endmodule
`default_nettype wire
